//--- include/usb_host_cmd_pkg.sv
// Constants and types for the host command and capability register block.
package usb_host_cmd_pkg;

  // Register byte offsets.
  localparam logic [7:0] CAP_OFFSET = 8'h08;
  localparam logic [7:0] CMD_OFFSET = 8'h10;
  localparam logic [7:0] STS_OFFSET = 8'h14;
  localparam logic [7:0] MASK_OFFSET = 8'h18;
  localparam logic [7:0] EDGE_OFFSET = 8'h88;

  // Values after reset.
  localparam logic [31:0] CAP_RESET = 32'h0000_0006;
  localparam logic [31:0] CMD_RESET = 32'h0008_0b00;
  localparam logic [31:0] STS_RESET = 32'h0000_1000;
  localparam logic [31:0] MASK_RESET = 32'h0000_0000;
  localparam logic [31:0] EDGE_RESET = 32'h0000_001f;

  // Writable and clearable bits.
  localparam logic [31:0] CMD_WRITE_MASK = 32'h00ff_0b7f;
  localparam logic [31:0] STS_CLEAR_MASK = 32'h0000_0020;
  localparam logic [31:0] MASK_WRITE_MASK = 32'h0000_0020;
  localparam logic [31:0] EDGE_WRITE_MASK = 32'h0000_031f;

  // Command field positions.
  localparam int RUN_BIT = 0;
  localparam int RESET_BIT = 1;
  localparam int LIST_SIZE_LO = 2;
  localparam int PERIODIC_BIT = 4;
  localparam int ASYNC_BIT = 5;
  localparam int DOORBELL_BIT = 6;
  localparam int PARK_COUNT_LO = 8;
  localparam int PARK_BIT = 11;
  localparam int RATE_LO = 16;

  // Status and edge control field positions.
  localparam int HALTED_BIT = 12;
  localparam int ADVANCE_BIT = 5;
  localparam int WIDTH_LO = 0;
  localparam int EDGE_MODE_BIT = 8;
  localparam int FULL_SPEED_BIT = 9;

  // Times and cycle counts.
  localparam int CLK_KHZ = 25000;
  localparam int UFRAME_NS = 125000;
  // Divided in two steps so that the product stays inside a 32-bit int.
  localparam int UFRAME_CYCLES = UFRAME_NS / 1000 * CLK_KHZ / 1000;
  localparam int RESET_NS = 1000;
  localparam int RESET_CYCLES = (RESET_NS * CLK_KHZ + 999999) / 1000000;
  localparam logic [7:0] RATE_UNLIMITED = 8'h01;

  // Bus data phase states and register selection.
  typedef enum logic [1:0] {BUS_IDLE, BUS_WAIT, BUS_DONE} bus_state_e;
  typedef enum logic [2:0] {SEL_NONE, SEL_CAP, SEL_CMD, SEL_STS, SEL_MASK, SEL_EDGE} reg_sel_e;

endpackage

//--- rtl/usb_host_cmd_regs.sv
// Host command, capability, status and interrupt registers behind an AHB-Lite slave.
//
// The AHB-Lite interface to the registers was decided locally.
`timescale 1ns/1ps
module usb_host_cmd_regs (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // Schedule engine feedback
  input wire logic async_advanced,
  input wire logic engine_idle,
  // Schedule engine controls
  output logic run_stop,
  output logic controller_reset,
  output logic [1:0] frame_list_size,
  output logic periodic_schedule_enable,
  output logic async_schedule_enable,
  output logic [1:0] park_transaction_count,
  output logic park_mode_enable,
  output logic [7:0] irq_rate_limit,
  // Interrupt
  output logic irq
);

  function automatic usb_host_cmd_pkg::reg_sel_e decode(input logic [7:0] offset);
    usb_host_cmd_pkg::reg_sel_e sel;
    sel = usb_host_cmd_pkg::SEL_NONE;
    if (offset == usb_host_cmd_pkg::CAP_OFFSET) begin
      sel = usb_host_cmd_pkg::SEL_CAP;
    end else if (offset == usb_host_cmd_pkg::CMD_OFFSET) begin
      sel = usb_host_cmd_pkg::SEL_CMD;
    end else if (offset == usb_host_cmd_pkg::STS_OFFSET) begin
      sel = usb_host_cmd_pkg::SEL_STS;
    end else if (offset == usb_host_cmd_pkg::MASK_OFFSET) begin
      sel = usb_host_cmd_pkg::SEL_MASK;
    end else if (offset == usb_host_cmd_pkg::EDGE_OFFSET) begin
      sel = usb_host_cmd_pkg::SEL_EDGE;
    end
    return sel;
  endfunction

  usb_host_cmd_pkg::bus_state_e state;
  usb_host_cmd_pkg::bus_state_e next_state;
  logic [7:0] addr_q;
  logic [7:0] next_addr_q;
  logic write_q;
  logic next_write_q;
  logic [31:0] next_hrdata;
  logic take;
  logic write_now;
  usb_host_cmd_pkg::reg_sel_e write_sel;

  logic [31:0] cmd;
  logic [31:0] next_cmd;
  logic [31:0] sts;
  logic [31:0] next_sts;
  logic [31:0] mask;
  logic [31:0] next_mask;
  logic [31:0] edge_ctrl;
  logic [31:0] next_edge_ctrl;
  logic [7:0] rst_cnt;
  logic [7:0] next_rst_cnt;

  logic [11:0] uf_cnt;
  logic [11:0] next_uf_cnt;
  logic [7:0] interval;
  logic [7:0] next_interval;
  logic irq_hold;
  logic next_irq_hold;
  logic [4:0] width_cnt;
  logic [4:0] next_width_cnt;
  logic next_irq;
  logic pending;
  logic issue_ok;
  logic edge_mode;

  // Bus decode: every access waits one cycle so read data comes from a flip-flop.
  assign take = hsel && htrans[1] && hready;
  assign write_now = (state == usb_host_cmd_pkg::BUS_WAIT) && write_q;
  assign write_sel = decode(addr_q);
  assign hreadyout = (state != usb_host_cmd_pkg::BUS_WAIT);
  assign hresp = 1'b0;

  always_comb begin
    next_state = state;
    next_addr_q = addr_q;
    next_write_q = write_q;
    next_hrdata = hrdata;
    case (state)
      usb_host_cmd_pkg::BUS_WAIT: begin
        next_state = usb_host_cmd_pkg::BUS_DONE;
        next_hrdata = 32'h0000_0000;
        if (!write_q) begin
          if (write_sel == usb_host_cmd_pkg::SEL_CAP) begin
            next_hrdata = usb_host_cmd_pkg::CAP_RESET;
          end else if (write_sel == usb_host_cmd_pkg::SEL_CMD) begin
            next_hrdata = cmd;
          end else if (write_sel == usb_host_cmd_pkg::SEL_STS) begin
            next_hrdata = sts;
          end else if (write_sel == usb_host_cmd_pkg::SEL_MASK) begin
            next_hrdata = mask;
          end else if (write_sel == usb_host_cmd_pkg::SEL_EDGE) begin
            next_hrdata = edge_ctrl;
          end
        end
      end
      default: begin
        if (take) begin
          next_state = usb_host_cmd_pkg::BUS_WAIT;
          next_addr_q = (haddr[1:0] == 2'h0) ? haddr[7:0] : 8'hff;
          next_write_q = hwrite;
        end else begin
          next_state = usb_host_cmd_pkg::BUS_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state <= usb_host_cmd_pkg::BUS_IDLE;
      addr_q <= 8'h00;
      write_q <= 1'b0;
      hrdata <= 32'h0000_0000;
    end else begin
      state <= next_state;
      addr_q <= next_addr_q;
      write_q <= next_write_q;
      hrdata <= next_hrdata;
    end
  end

  // Register state: command, status, mask, edge control and reset countdown.
  always_comb begin
    next_cmd = cmd;
    next_sts = sts;
    next_mask = mask;
    next_edge_ctrl = edge_ctrl;
    next_rst_cnt = rst_cnt;
    if (cmd[usb_host_cmd_pkg::RUN_BIT]) begin
      next_sts[usb_host_cmd_pkg::HALTED_BIT] = 1'b0;
    end else if (engine_idle) begin
      next_sts[usb_host_cmd_pkg::HALTED_BIT] = 1'b1;
    end
    if (cmd[usb_host_cmd_pkg::DOORBELL_BIT] && async_advanced) begin
      next_cmd[usb_host_cmd_pkg::DOORBELL_BIT] = 1'b0;
    end
    if (write_now) begin
      // Command writes are refused while a controller reset is running.
      if (write_sel == usb_host_cmd_pkg::SEL_CMD && rst_cnt == 8'h00) begin
        next_cmd = hwdata & usb_host_cmd_pkg::CMD_WRITE_MASK;
        if (hwdata[usb_host_cmd_pkg::RESET_BIT]) begin
          next_cmd = usb_host_cmd_pkg::CMD_RESET;
          next_cmd[usb_host_cmd_pkg::RESET_BIT] = 1'b1;
          next_rst_cnt = 8'(usb_host_cmd_pkg::RESET_CYCLES);
        end
      end else if (write_sel == usb_host_cmd_pkg::SEL_STS) begin
        next_sts = next_sts & ~(hwdata & usb_host_cmd_pkg::STS_CLEAR_MASK);
      end else if (write_sel == usb_host_cmd_pkg::SEL_MASK) begin
        next_mask = hwdata & usb_host_cmd_pkg::MASK_WRITE_MASK;
      end else if (write_sel == usb_host_cmd_pkg::SEL_EDGE) begin
        next_edge_ctrl = hwdata & usb_host_cmd_pkg::EDGE_WRITE_MASK;
      end
    end
    if (cmd[usb_host_cmd_pkg::DOORBELL_BIT] && async_advanced) begin
      next_sts[usb_host_cmd_pkg::ADVANCE_BIT] = 1'b1;
    end
    if (rst_cnt != 8'h00) begin
      next_rst_cnt = rst_cnt - 8'h01;
      next_sts = usb_host_cmd_pkg::STS_RESET;
      next_mask = usb_host_cmd_pkg::MASK_RESET;
      if (rst_cnt == 8'h01) begin
        next_cmd[usb_host_cmd_pkg::RESET_BIT] = 1'b0;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cmd <= usb_host_cmd_pkg::CMD_RESET;
      sts <= usb_host_cmd_pkg::STS_RESET;
      mask <= usb_host_cmd_pkg::MASK_RESET;
      edge_ctrl <= usb_host_cmd_pkg::EDGE_RESET;
      rst_cnt <= 8'h00;
    end else begin
      cmd <= next_cmd;
      sts <= next_sts;
      mask <= next_mask;
      edge_ctrl <= next_edge_ctrl;
      rst_cnt <= next_rst_cnt;
    end
  end

  assign run_stop = cmd[usb_host_cmd_pkg::RUN_BIT];
  assign controller_reset = cmd[usb_host_cmd_pkg::RESET_BIT];
  assign frame_list_size = cmd[usb_host_cmd_pkg::LIST_SIZE_LO +: 2];
  assign periodic_schedule_enable = cmd[usb_host_cmd_pkg::PERIODIC_BIT];
  assign async_schedule_enable = cmd[usb_host_cmd_pkg::ASYNC_BIT];
  assign park_transaction_count = cmd[usb_host_cmd_pkg::PARK_COUNT_LO +: 2];
  assign park_mode_enable = cmd[usb_host_cmd_pkg::PARK_BIT];
  assign irq_rate_limit = cmd[usb_host_cmd_pkg::RATE_LO +: 8];

  // Interrupt pacing counts micro-frames since the last issue and saturates.
  assign pending = |(sts & mask);
  assign edge_mode = edge_ctrl[usb_host_cmd_pkg::EDGE_MODE_BIT];

  always_comb begin
    next_uf_cnt = uf_cnt + 12'h001;
    next_interval = interval;
    next_irq_hold = irq_hold;
    next_width_cnt = width_cnt;
    // 00h and 01h and full speed are unlimited
    issue_ok = edge_ctrl[usb_host_cmd_pkg::FULL_SPEED_BIT] ||
      irq_rate_limit <= usb_host_cmd_pkg::RATE_UNLIMITED || interval >= irq_rate_limit;
    if (uf_cnt == 12'(usb_host_cmd_pkg::UFRAME_CYCLES - 1)) begin
      next_uf_cnt = 12'h000;
      if (interval != 8'hff) begin
        next_interval = interval + 8'h01;
      end
    end
    if (width_cnt != 5'h00) begin
      next_width_cnt = width_cnt - 5'h01;
    end
    if (pending && !irq_hold && issue_ok) begin
      next_irq_hold = 1'b1;
      next_interval = 8'h00;
      if (edge_mode) begin
        next_width_cnt = edge_ctrl[usb_host_cmd_pkg::WIDTH_LO +: 5];
      end
    end else if (!pending) begin
      next_irq_hold = 1'b0;
    end
    // Edge mode shows a fixed-width pulse, so a long pending level cannot retrigger.
    next_irq = edge_mode ? (next_width_cnt != 5'h00) : next_irq_hold;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      uf_cnt <= 12'h000;
      interval <= 8'h00;
      irq_hold <= 1'b0;
      width_cnt <= 5'h00;
      irq <= 1'b0;
    end else begin
      uf_cnt <= next_uf_cnt;
      interval <= next_interval;
      irq_hold <= next_irq_hold;
      width_cnt <= next_width_cnt;
      irq <= next_irq;
    end
  end

endmodule

//--- tb/usb_host_cmd_properties.sv
// Checker for the host command block ports.
`timescale 1ns/1ps
module usb_host_cmd_properties (
  // Clock, reset and bus
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic [31:0] hrdata,
  // Engine controls
  input wire logic run_stop,
  input wire logic controller_reset,
  input wire logic [1:0] frame_list_size,
  input wire logic periodic_schedule_enable,
  input wire logic async_schedule_enable,
  input wire logic [1:0] park_transaction_count,
  input wire logic park_mode_enable,
  input wire logic [7:0] irq_rate_limit
);
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  logic tk;
  assign tk = hsel && htrans[1] && hready;
  a_bus_wait: assert property (tk |=> !hreadyout ##1 hreadyout)
    else $error("bus wait cycle wrong");
  a_resp_okay: assert property (hresp == 1'b0)
    else $error("bus response not okay");
  a_cap_read: assert property (tk && !hwrite && haddr == 32'h8 |-> ##2 hrdata == 32'h6)
    else $error("capability read wrong");
  a_cmd_write: assert property (tk && hwrite
    && haddr == 32'h10 && !controller_reset ##1 !hwdata[1]
    |=> run_stop == $past(hwdata[0]) && frame_list_size == $past(hwdata[3:2])
    && periodic_schedule_enable == $past(hwdata[4])
    && park_transaction_count == $past(hwdata[9:8])
    && async_schedule_enable == $past(hwdata[5]) && park_mode_enable == $past(hwdata[11])
    && irq_rate_limit == $past(hwdata[23:16]))
    else $error("command write not applied");
  a_reset_vals: assert property ($rose(hresetn)
    |-> !run_stop && park_mode_enable
    && park_transaction_count == 2'b11 && irq_rate_limit == 8'h08 && frame_list_size == 2'b00)
    else $error("command reset value wrong");
  a_reset_req: assert property (tk && hwrite && haddr == 32'h10 ##1 hwdata[1]
    |=> controller_reset && !run_stop)
    else $error("controller reset not started");
  a_reset_done: assert property ($rose(controller_reset)
    |-> controller_reset [*8] ##[1:30] !controller_reset)
    else $error("controller reset did not end");
  a_reset_lock: assert property (controller_reset && $past(controller_reset)
    |-> $stable(irq_rate_limit) && !run_stop)
    else $error("command changed during reset");
endmodule
bind usb_host_cmd_regs usb_host_cmd_properties usb_host_cmd_properties_inst (.hclk, .hresetn,
  .hsel, .haddr, .htrans, .hwrite, .hwdata, .hready, .hreadyout, .hresp, .hrdata, .run_stop,
  .controller_reset, .frame_list_size, .periodic_schedule_enable, .async_schedule_enable,
  .park_transaction_count, .park_mode_enable, .irq_rate_limit);

//--- tb/tb.sv
// Self-checking bench for the host command block.
`timescale 1ns/1ps
module tb;
  logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, adv = 0, idle = 1;
  logic [31:0] haddr = 0, hwdata = 0, rd, cv, hrdata;
  logic [1:0] htrans = 0;
  logic [2:0] hsize = 3'h2;
  wire logic hready;
  logic hresp, irq, rs, cr, pe, ae, pk;
  logic [1:0] fs, pc;
  logic [7:0] rl;
  int fails = 0, compares = 0, n;
  always #20 hclk = ~hclk;
  assign cv = {8'h00, rl, 4'h0, pk, 1'b0, pc, 2'h0, ae, pe, fs, cr, rs};
  usb_host_cmd_regs usb_host_cmd_regs_inst (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hready), .hreadyout(hready), .hresp(hresp), .hrdata(hrdata), .async_advanced(adv),
    .engine_idle(idle), .run_stop(rs), .controller_reset(cr), .frame_list_size(fs),
    .periodic_schedule_enable(pe), .async_schedule_enable(ae), .park_transaction_count(pc),
    .park_mode_enable(pk), .irq_rate_limit(rl), .irq(irq));
  task automatic tally_and_finish;
    $display("fails=%0d compares=%0d", fails, compares);
    if (fails == 0 && compares > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    compares++;
    if (g !== e) begin
      fails++;
      $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  // Waits for hready at a falling edge and samples hrdata there, then steps to the next rising edge.
  task automatic rdy;
    n = 0;
    @(negedge hclk);
    while (hready !== 1'b1) begin
      n++;
      if (n > 50) begin
        fails++;
        tally_and_finish;
      end
      @(negedge hclk);
    end
    rd = hrdata;
    @(posedge hclk);
  endtask
  task automatic ahb(input logic w, input logic [31:0] a, input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= a;
    rdy;
    hsel <= 0;
    htrans <= 2'h0;
    hwdata <= d;
    rdy;
  endtask
  task automatic rchk(input logic [31:0] a, input logic [31:0] e);
    ahb(0, a, 32'h0);
    chk(rd, e);
  endtask
  task automatic ring(input logic [7:0] thr);
    ahb(1, 32'h10, {8'h00, thr, 16'h0071});
    @(posedge hclk);
    adv <= 1;
    @(posedge hclk);
    adv <= 0;
  endtask
  task automatic s_reset_vals;
    rchk(32'h08, 32'h0000_0006);
    rchk(32'h10, 32'h0008_0b00);
    chk(cv, 32'h0008_0b00);
    rchk(32'h14, 32'h0000_1000);
    rchk(32'h0c, 32'h0);
  endtask
  // Every documented threshold code, with read-only bits 7, 10 and 31:24 written as ones.
  task automatic s_fields;
    logic [7:0] v;
    logic [31:0] d;
    idle <= 0;
    for (int i = 0; i < 7; i++) begin
      v = 8'h01 << i;
      d = {8'h00, v, 16'h0215} ^ (i[0] ? 32'h0000_0a3c : 32'h0);
      ahb(1, 32'h10, d | 32'hff00_0480);
      chk(cv, d);
      rchk(32'h10, d);
    end
    rchk(32'h14, 32'h0);
  endtask
  // Writing stop alone must not report halted until the engine is idle.
  task automatic s_halt;
    ahb(1, 32'h10, 32'h0001_0000);
    rchk(32'h14, 32'h0);
    idle <= 1;
    rchk(32'h14, 32'h0000_1000);
    idle <= 0;
  endtask
  task automatic s_doorbell;
    ahb(1, 32'h18, 32'h20);
    ring(8'h01);
    rchk(32'h10, 32'h0001_0031);
    rchk(32'h14, 32'h20);
    chk(irq, 1'b1);
    ahb(1, 32'h14, 32'h20);
    rchk(32'h14, 32'h0);
    chk(irq, 1'b0);
    ahb(1, 32'h18, 32'h0);
    ring(8'h01);
    rchk(32'h14, 32'h20);
    chk(irq, 1'b0);
    ahb(1, 32'h14, 32'h20);
  endtask
  // Threshold 02h holds a new interrupt back for two micro-frames; full speed lifts the limit.
  task automatic s_pace;
    ahb(1, 32'h18, 32'h20);
    ring(8'h02);
    repeat (40) @(negedge hclk);
    chk(irq, 1'b0);
    for (n = 0; n < 7000 && irq !== 1'b1; n++) @(negedge hclk);
    chk(irq, 1'b1);
    ahb(1, 32'h14, 32'h20);
    ahb(1, 32'h88, 32'h21f);
    ring(8'h02);
    repeat (3) @(negedge hclk);
    chk(irq, 1'b1);
    ahb(1, 32'h14, 32'h20);
  endtask
  // Edge mode with a fixed four-cycle width; the pulse is measured at the pin.
  task automatic s_edge;
    int w;
    w = 0;
    ahb(1, 32'h88, 32'h104);
    ahb(1, 32'h18, 32'h20);
    ring(8'h01);
    repeat (40) begin
      @(negedge hclk);
      if (irq === 1'b1) w++;
    end
    chk(w, 4);
    ahb(1, 32'h14, 32'h20);
  endtask
  task automatic s_ctl_reset;
    ahb(1, 32'h10, 32'h0001_0003);
    chk({cr, rs}, 2'b10);
    for (n = 0; n < 60 && cr === 1'b1; n++) @(negedge hclk);
    chk(cr, 1'b0);
    rchk(32'h10, 32'h0008_0b00);
    rchk(32'h88, 32'h104);
  endtask
  initial begin
    repeat (16) @(posedge hclk);
    hresetn <= 1;
    s_reset_vals;
    s_fields;
    s_halt;
    s_doorbell;
    s_pace;
    s_edge;
    s_ctl_reset;
    tally_and_finish;
  end
endmodule
